// File: pkg/isr_map.vh
// register field positions, reset values and error codes of the status reporting core
`ifndef ISR_MAP_VH
`define ISR_MAP_VH
// status summary byte positions
`define ISR_SSB_EEQ 2
`define ISR_SSB_QUES 3
`define ISR_SSB_MAV 4
`define ISR_SSB_ESB 5
`define ISR_SSB_RQS 6
`define ISR_SSB_OPER 7
// standard event latch positions
`define ISR_SEL_OPC 0
`define ISR_SEL_NU 1
`define ISR_SEL_QYE 2
`define ISR_SEL_DDE 3
`define ISR_SEL_EXE 4
`define ISR_SEL_CME 5
`define ISR_SEL_URQ 6
`define ISR_SEL_PON 7
// reset values
`define ISR_BYTE_RST 8'h00
`define ISR_WORD_RST 16'h0000
// error codes are magnitudes: code = -(mag)
`define ISR_ERR_NONE 10'h000
`define ISR_ERR_CMD 10'h064
`define ISR_ERR_EXE_LO 10'h0C8
`define ISR_ERR_EXE_HI 10'h12B
`define ISR_ERR_DEV_LO 10'h12C
`define ISR_ERR_DEV_HI 10'h14A
`define ISR_ERR_OVF 10'h15E
`define ISR_ERR_QRY_LO 10'h190
`define ISR_ERR_QRY_HI 10'h1F3
`endif

// File: rtl/isr_edge_latch.v
// rising-edge event latch with read-clear and clear-status
`timescale 1ns/1ps
module isr_edge_latch #(
  parameter W = 16
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // condition and control
  input wire [W-1:0] cond,
  input wire [W-1:0] set_pulse,
  input wire clr,
  // latch content
  output reg [W-1:0] latch_q
);
  reg [W-1:0] cond_q;
  wire [W-1:0] rise;
  wire [W-1:0] latch_d;

  assign rise = (cond & ~cond_q) | set_pulse;
  // set wins over clear so an event in the clearing cycle is kept
  assign latch_d = (clr ? {W{1'b0}} : latch_q) | rise;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cond_q <= {W{1'b0}};
      latch_q <= {W{1'b0}};
    end else begin
      cond_q <= cond;
      latch_q <= latch_d;
    end
  end
endmodule // isr_edge_latch

// File: rtl/isr_err_fifo.v
// error/event fifo holding error magnitudes with overflow marker
`timescale 1ns/1ps
`include "isr_map.vh"
module isr_err_fifo #(
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // push side
  input wire push,
  input wire [9:0] push_code,
  // pop side
  input wire pop,
  input wire clr,
  output wire [9:0] head_code,
  output wire not_empty
);
  reg [9:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  reg locked_q;
  wire full;
  wire do_pop;
  wire do_push;
  wire last_slot;

  assign full = (cnt_q == DEPTH[AW:0]);
  assign not_empty = (cnt_q != {(AW+1){1'b0}});
  assign do_pop = pop & not_empty;
  // the last free slot takes the overflow code, then pushes stop until a read
  assign last_slot = (cnt_q == DEPTH[AW:0] - {{AW{1'b0}}, 1'b1}) & ~do_pop;
  assign do_push = push & ~locked_q & ~full;
  assign head_code = not_empty ? mem[rd_q] : `ISR_ERR_NONE;

  always @(posedge sys_clk) begin
    if (do_push) begin
      mem[wr_q] <= last_slot ? `ISR_ERR_OVF : push_code;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      locked_q <= 1'b0;
    end else if (clr) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      locked_q <= 1'b0;
    end else begin
      if (do_push) begin
        wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_pop) begin
        rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
      if (do_pop) begin
        locked_q <= 1'b0;
      end else if (do_push & last_slot) begin
        locked_q <= 1'b1;
      end
    end
  end
endmodule // isr_err_fifo

// File: rtl/isr_status_core.v
// status byte, standard event latch, enable masks, output queue and error queue
// Function
// - status byte positions 0 and 1 always read zero
// - position 2 set while an error code waits in the queue
// - position 3 is the enabled questionable latch summary
// - position 4 set while unread response data sits in output queue
// - position 5 is the enabled standard event latch summary
// - position 6 reports the service request to a serial poll
// - position 7 is the operation latch summary
// - event bit 0 set when pending operations finish after opc; bit 1 zero
// - event bit 2 on query error, bit 3 on device error
// - event bit 4 on execution error, bit 5 on command error
// - event bit 6 on local button, bit 7 after power on
// - reading the standard event latch returns it then clears it
// - each summary is the OR of status AND enable pairs
// - standard event enable mask aligned with the latch, writable and readable
// - operation enable mask exists but operation sources report nothing
// - questionable enable mask selects questionable events into the summary
// - service request enable mask selects status bits raising a request
// - output queue cleared when a new message starts after a terminator
// - error queue is first-in first-out; error query pops the oldest
// - overflow records code 350 negative and refuses messages until read
// - queued error codes also set their matching standard event bit
// - event latch bits set on rising condition and hold until read
// - clear status resets all event latches
// - questionable latch query returns content then clears it
`timescale 1ns/1ps
`include "isr_map.vh"
module isr_status_core #(
  parameter OQ_DEPTH = 16,
  parameter OQ_AW = 4,
  parameter EQ_DEPTH = 8,
  parameter EQ_AW = 3
) (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // command strobes from the parser, same clock
  input wire cls_cmd,
  input wire opc_cmd,
  input wire ops_done,
  input wire msg_start,
  input wire ese_wr,
  input wire sre_wr,
  input wire qen_wr,
  input wire oen_wr,
  input wire [15:0] wr_data,
  input wire esr_rd,
  input wire qev_rd,
  input wire err_rd,
  // error reports
  input wire err_push,
  input wire [9:0] err_code,
  // output queue fill and drain
  input wire oq_wr,
  input wire [7:0] oq_wdata,
  input wire oq_rd,
  // condition inputs from outside the clock domain
  input wire [15:0] ques_cond_pin,
  input wire local_btn_pin,
  // read back values
  output reg [7:0] status_summary_byte_q,
  output reg [7:0] standard_event_latch_q,
  output reg [7:0] ese_mask_q,
  output reg [7:0] sre_mask_q,
  output reg [15:0] ques_mask_q,
  output reg [15:0] oper_mask_q,
  output reg [15:0] ques_latch_rd_q,
  output reg [9:0] err_rd_q,
  output reg [7:0] oq_rdata_q,
  output reg oq_rvalid_q,
  // service request line, open drain: oe low drives it low
  output reg srq_out_q,
  output reg srq_oe_n_q
);
  // ***********************************
  // input synchronisers
  // ***********************************
  reg [15:0] ques_s1_q;
  reg [15:0] ques_s2_q;
  reg btn_s1_q;
  reg btn_s2_q;
  reg pon_q;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ques_s1_q <= `ISR_WORD_RST;
      ques_s2_q <= `ISR_WORD_RST;
      btn_s1_q <= 1'b0;
      btn_s2_q <= 1'b0;
      pon_q <= 1'b1;
    end else begin
      ques_s1_q <= ques_cond_pin;
      ques_s2_q <= ques_s1_q;
      btn_s1_q <= local_btn_pin;
      btn_s2_q <= btn_s1_q;
      pon_q <= 1'b0;
    end
  end

  // ***********************************
  // masks
  // ***********************************
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ese_mask_q <= `ISR_BYTE_RST;
      sre_mask_q <= `ISR_BYTE_RST;
      ques_mask_q <= `ISR_WORD_RST;
      oper_mask_q <= `ISR_WORD_RST;
    end else begin
      if (ese_wr) begin
        ese_mask_q <= wr_data[7:0];
      end
      if (sre_wr) begin
        sre_mask_q <= wr_data[7:0];
      end
      if (qen_wr) begin
        ques_mask_q <= wr_data;
      end
      if (oen_wr) begin
        oper_mask_q <= wr_data;
      end
    end
  end

  // ***********************************
  // operation complete tracking
  // ***********************************
  reg opc_armed_q;
  wire opc_fire;
  assign opc_fire = opc_armed_q & ops_done;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      opc_armed_q <= 1'b0;
    end else if (opc_cmd) begin
      opc_armed_q <= 1'b1;
    end else if (opc_fire | cls_cmd) begin
      opc_armed_q <= 1'b0;
    end
  end

  // ***********************************
  // error code to event mapping
  // ***********************************
  reg [7:0] err_events;
  always @* begin
    err_events = 8'h00;
    if (err_push) begin
      if (err_code == `ISR_ERR_CMD) begin
        err_events[`ISR_SEL_CME] = 1'b1;
      end else if (err_code >= `ISR_ERR_EXE_LO && err_code <= `ISR_ERR_EXE_HI) begin
        err_events[`ISR_SEL_EXE] = 1'b1;
      end else if (err_code >= `ISR_ERR_DEV_LO && err_code <= `ISR_ERR_DEV_HI) begin
        err_events[`ISR_SEL_DDE] = 1'b1;
      end else if (err_code >= `ISR_ERR_QRY_LO && err_code <= `ISR_ERR_QRY_HI) begin
        err_events[`ISR_SEL_QYE] = 1'b1;
      end
    end
  end

  // ***********************************
  // event latches
  // ***********************************
  wire [7:0] sel_set;
  wire [7:0] sel_cond;
  wire [7:0] sel_latch;
  wire [15:0] ques_latch;
  wire [15:0] oper_latch;

  assign sel_set = err_events
    | ({7'h00, opc_fire} << `ISR_SEL_OPC)
    | ({7'h00, pon_q} << `ISR_SEL_PON);
  // a held button is a level: only its rising edge may set the bit, else clear cannot win
  assign sel_cond = {7'h00, btn_s2_q} << `ISR_SEL_URQ;

  // standard latch: read or clear-status empties it
  isr_edge_latch #(
    .W(8)
  ) u_sel (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .cond(sel_cond),
    .set_pulse(sel_set),
    .clr(esr_rd | cls_cmd),
    .latch_q(sel_latch)
  );

  // questionable latch: rising edges, query clears
  isr_edge_latch #(
    .W(16)
  ) u_ques (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .cond(ques_s2_q),
    .set_pulse(16'h0000),
    .clr(qev_rd | cls_cmd),
    .latch_q(ques_latch)
  );

  isr_edge_latch #(
    .W(16)
  ) u_oper (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .cond(16'h0000),
    .set_pulse(16'h0000),
    .clr(cls_cmd),
    .latch_q(oper_latch)
  );

  // ***********************************
  // error/event queue
  // ***********************************
  wire [9:0] eq_head;
  wire eq_pending;

  isr_err_fifo #(
    .DEPTH(EQ_DEPTH),
    .AW(EQ_AW)
  ) u_errq (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .push(err_push),
    .push_code(err_code),
    .pop(err_rd),
    .clr(cls_cmd),
    .head_code(eq_head),
    .not_empty(eq_pending)
  );

  // ***********************************
  // output queue
  // ***********************************
  reg [7:0] oq_mem [0:OQ_DEPTH-1];
  reg [OQ_AW-1:0] oq_wp_q;
  reg [OQ_AW-1:0] oq_rp_q;
  reg [OQ_AW:0] oq_cnt_q;
  wire oq_full;
  wire oq_avail;
  wire oq_push;
  wire oq_pop;

  assign oq_full = (oq_cnt_q == OQ_DEPTH[OQ_AW:0]);
  assign oq_avail = (oq_cnt_q != {(OQ_AW+1){1'b0}});
  // excess response bytes are dropped while full
  assign oq_push = oq_wr & ~oq_full & ~msg_start;
  assign oq_pop = oq_rd & oq_avail & ~msg_start;

  always @(posedge sys_clk) begin
    if (oq_push) begin
      oq_mem[oq_wp_q] <= oq_wdata;
    end
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      oq_wp_q <= {OQ_AW{1'b0}};
      oq_rp_q <= {OQ_AW{1'b0}};
      oq_cnt_q <= {(OQ_AW+1){1'b0}};
    end else if (msg_start) begin
      oq_wp_q <= {OQ_AW{1'b0}};
      oq_rp_q <= {OQ_AW{1'b0}};
      oq_cnt_q <= {(OQ_AW+1){1'b0}};
    end else begin
      if (oq_push) begin
        oq_wp_q <= oq_wp_q + {{(OQ_AW-1){1'b0}}, 1'b1};
      end
      if (oq_pop) begin
        oq_rp_q <= oq_rp_q + {{(OQ_AW-1){1'b0}}, 1'b1};
      end
      oq_cnt_q <= oq_cnt_q + {{OQ_AW{1'b0}}, oq_push} - {{OQ_AW{1'b0}}, oq_pop};
    end
  end

  // ***********************************
  // summaries and status byte
  // ***********************************
  wire ques_sum;
  wire esb_sum;
  wire oper_sum;
  wire [7:0] ssb_raw;
  wire rqs;
  reg [7:0] ssb_d;

  assign ques_sum = |(ques_latch & ques_mask_q);
  assign esb_sum = |(sel_latch & ese_mask_q);
  assign oper_sum = |(oper_latch & oper_mask_q);

  always @* begin
    ssb_d = 8'h00;
    ssb_d[`ISR_SSB_EEQ] = eq_pending;
    ssb_d[`ISR_SSB_QUES] = ques_sum;
    ssb_d[`ISR_SSB_MAV] = oq_avail;
    ssb_d[`ISR_SSB_ESB] = esb_sum;
    ssb_d[`ISR_SSB_OPER] = oper_sum;
  end

  assign ssb_raw = ssb_d;
  // request when enabled bit other than 6 set
  assign rqs = |(ssb_raw & sre_mask_q & ~(8'h01 << `ISR_SSB_RQS));

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_summary_byte_q <= `ISR_BYTE_RST;
      standard_event_latch_q <= `ISR_BYTE_RST;
      ques_latch_rd_q <= `ISR_WORD_RST;
      err_rd_q <= `ISR_ERR_NONE;
      oq_rdata_q <= `ISR_BYTE_RST;
      oq_rvalid_q <= 1'b0;
      srq_out_q <= 1'b0;
      srq_oe_n_q <= 1'b1;
    end else begin
      // request bit seen by serial poll
      status_summary_byte_q <= ssb_raw | ({7'h00, rqs} << `ISR_SSB_RQS);
      standard_event_latch_q <= sel_latch & ~(8'h01 << `ISR_SEL_NU);
      ques_latch_rd_q <= ques_latch;
      if (err_rd) begin
        err_rd_q <= eq_head;
      end
      if (oq_pop) begin
        oq_rdata_q <= oq_mem[oq_rp_q];
      end
      oq_rvalid_q <= oq_pop;
      srq_out_q <= 1'b0;
      srq_oe_n_q <= ~rqs;
    end
  end
endmodule // isr_status_core

// File: dv/isr_status_core_properties.sv
// concurrent checks on the status reporting core ports
`timescale 1ns/1ps
module isr_status_checker (
  // clock and reset
  input logic sys_clk,
  input logic rst_n,
  // strobes
  input logic cls_cmd,
  input logic msg_start,
  input logic esr_rd,
  input logic err_rd,
  input logic err_push,
  input logic oq_wr,
  input logic oq_rd,
  // outputs
  input logic [7:0] status_summary_byte_q,
  input logic [7:0] standard_event_latch_q,
  input logic [7:0] ese_mask_q,
  input logic [7:0] sre_mask_q,
  input logic oq_rvalid_q,
  input logic srq_out_q,
  input logic srq_oe_n_q
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  chk_low_zero: assert property (status_summary_byte_q[1:0] == 2'b00)
    else $error("status byte low positions not zero");
  chk_nu_event: assert property (standard_event_latch_q[1] == 1'b0)
    else $error("event position 1 not zero");
  chk_oper_idle: assert property (status_summary_byte_q[7] == 1'b0)
    else $error("operation summary active");
  // summaries only compared once their inputs have settled
  chk_esb_sum: assert property (($stable(standard_event_latch_q) && $stable(ese_mask_q))[*3]
    |-> status_summary_byte_q[5] == |(standard_event_latch_q & ese_mask_q))
    else $error("event summary wrong");
  chk_rqs_sum: assert property (($stable(status_summary_byte_q) && $stable(sre_mask_q))[*3]
    |-> status_summary_byte_q[6] ==
    |({status_summary_byte_q[7], 1'b0, status_summary_byte_q[5:0]} & sre_mask_q))
    else $error("request summary wrong");
  chk_srq_pin: assert property (srq_out_q == 1'b0 && srq_oe_n_q == !status_summary_byte_q[6])
    else $error("service request pin disagrees with status byte");
  chk_eeq_set: assert property (err_push && !err_rd && !cls_cmd ##1 !err_rd && !cls_cmd
    |-> ##1 status_summary_byte_q[2])
    else $error("error pending bit missing");
  chk_mav_set: assert property (oq_wr && !oq_rd && !msg_start ##1 !oq_rd && !msg_start
    |-> ##1 status_summary_byte_q[4])
    else $error("message available bit missing");
  chk_rvalid_cause: assert property (oq_rvalid_q |-> $past(oq_rd))
    else $error("read data valid without read");
  chk_esr_clear: assert property (esr_rd && !err_push && !cls_cmd ##1 !err_push
    |-> ##1 standard_event_latch_q[5:2] == 4'h0)
    else $error("event latch not cleared by read");
  cov_srq: cover property (!srq_oe_n_q);
  cov_rvalid: cover property (oq_rvalid_q);
  cov_esr: cover property (esr_rd && standard_event_latch_q != 8'h00);
endmodule // isr_status_checker

bind isr_status_core isr_status_checker chk_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .cls_cmd(cls_cmd), .msg_start(msg_start),
  .esr_rd(esr_rd), .err_rd(err_rd), .err_push(err_push), .oq_wr(oq_wr), .oq_rd(oq_rd),
  .status_summary_byte_q(status_summary_byte_q),
  .standard_event_latch_q(standard_event_latch_q), .ese_mask_q(ese_mask_q),
  .sre_mask_q(sre_mask_q), .oq_rvalid_q(oq_rvalid_q), .srq_out_q(srq_out_q),
  .srq_oe_n_q(srq_oe_n_q)
);

// File: dv/isr_ctrl_model.sv
// bus controller side: pulled-up service request line and serial poll capture
`timescale 1ns/1ps
module isr_ctrl_model (
  // clock
  input logic sys_clk,
  // service request pin
  input logic srq_out,
  input logic srq_oe_n,
  // serial poll
  input logic poll,
  input logic [7:0] status_byte,
  output logic [7:0] poll_byte,
  output logic srq_line
);
  // open drain line
  // the pull-up wins whenever the device lets go
  assign srq_line = srq_oe_n ? 1'b1 : srq_out;
  always @(posedge sys_clk) begin
    if (poll) begin
      poll_byte <= status_byte;
    end
  end
endmodule // isr_ctrl_model

// File: dv/test_instrument_status_reporting.sv
// self-checking bench for the status reporting core
`timescale 1ns/1ps
module test_instrument_status_reporting;
  // ****************
  // signals
  // ****************
  localparam CLS = 0, OPC = 1, DONE = 2, MSG = 3, ESE = 4, SRE = 5, QEN = 6, OEN = 7;
  localparam ESR = 8, QRD = 9, ERD = 10, PUSH = 11, OQW = 12, OQR = 13;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic poll = 1'b0;
  logic local_btn_pin = 1'b0;
  logic [13:0] stb = 14'h0000;
  logic [15:0] wr_data = 16'h0000;
  logic [15:0] ques_cond_pin = 16'h0000;
  logic [9:0] err_code = 10'h000;
  logic [7:0] oq_wdata = 8'h00;
  logic [9:0] codes [0:8] = '{10'h064, 10'h0DD, 10'h12C, 10'h14A, 10'h19A, 10'h0C9,
    10'h0CA, 10'h15E, 10'h000};
  logic [7:0] ev [0:4] = '{8'h20, 8'h10, 8'h08, 8'h08, 8'h04};
  wire [7:0] sb, sel, ese_m, sre_m, oq_rdata, poll_byte;
  wire [15:0] qm, om, qrd;
  wire [9:0] err_rd_q;
  wire oq_rvalid, srq_out, srq_oe_n, srq_line;
  integer failures = 0;
  integer n_checks = 0;
  integer i;
  always #2 sys_clk = ~sys_clk;
  isr_status_core uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .cls_cmd(stb[CLS]), .opc_cmd(stb[OPC]),
    .ops_done(stb[DONE]), .msg_start(stb[MSG]), .ese_wr(stb[ESE]), .sre_wr(stb[SRE]),
    .qen_wr(stb[QEN]), .oen_wr(stb[OEN]), .wr_data(wr_data), .esr_rd(stb[ESR]),
    .qev_rd(stb[QRD]), .err_rd(stb[ERD]), .err_push(stb[PUSH]), .err_code(err_code),
    .oq_wr(stb[OQW]), .oq_wdata(oq_wdata), .oq_rd(stb[OQR]),
    .ques_cond_pin(ques_cond_pin), .local_btn_pin(local_btn_pin),
    .status_summary_byte_q(sb), .standard_event_latch_q(sel), .ese_mask_q(ese_m),
    .sre_mask_q(sre_m), .ques_mask_q(qm), .oper_mask_q(om), .ques_latch_rd_q(qrd),
    .err_rd_q(err_rd_q), .oq_rdata_q(oq_rdata), .oq_rvalid_q(oq_rvalid),
    .srq_out_q(srq_out), .srq_oe_n_q(srq_oe_n)
  );
  isr_ctrl_model ctrl (
    .sys_clk(sys_clk), .srq_out(srq_out), .srq_oe_n(srq_oe_n), .poll(poll),
    .status_byte(sb), .poll_byte(poll_byte), .srq_line(srq_line)
  );
  // ****************
  // tasks
  // ****************
  // strobes stand for exactly one cycle, so calls may follow back to back
  task go(input [13:0] m);
    begin
      stb = m;
      @(posedge sys_clk);
      #1;
    end
  endtask
  task idle(input integer n);
    repeat (n) go(14'h0000);
  endtask
  task chk(input [8*8-1:0] nm, input [15:0] e, input [15:0] g);
    begin
      n_checks++;
      if (g !== e) begin
        failures++;
        $display("unexpected %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task final_report;
    begin
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  // pin inputs pass a synchroniser, so their delay is only bounded
  task wt(input integer k);
    integer t;
    begin
      t = 0;
      while (((k < 8) ? sb[k] : sel[k-8]) !== 1'b1 && t < 20) begin
        go(14'h0000);
        t++;
      end
      if (t == 20) begin
        failures++;
        $display("unexpected wait %0d exp 1 got 0", k);
        final_report;
      end
    end
  endtask
  // ****************
  // tests
  // ****************
  initial begin
    repeat (8) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    idle(3);
    chk("pon", 16'h0080, sel);
    chk("sbyte", 16'h0000, sb);
    chk("srqline", 16'h0001, srq_line);
    go(14'h1 << ESR);
    idle(2);
    $display("test reset done");
    for (i = 0; i < 5; i++) begin
      err_code = codes[i];
      go(14'h1 << PUSH);
      idle(2);
      chk("evbit", {8'h00, ev[i]}, {8'h00, sel & 8'h3C});
      chk("eeq", 16'h0001, sb[2]);
      go(14'h1 << ESR);
      idle(2);
      chk("rdclr", 16'h0000, sel & 8'h3C);
    end
    $display("test error classes done");
    for (i = 5; i < 9; i++) begin
      err_code = (i < 7) ? codes[i] : codes[5];
      go(14'h1 << PUSH);
    end
    for (i = 0; i < 9; i++) begin
      go(14'h1 << ERD);
      go(14'h0000);
      chk("errq", {6'h00, codes[i]}, {6'h00, err_rd_q});
    end
    idle(1);
    chk("eeq", 16'h0000, sb[2]);
    go(14'h1 << ESR);
    idle(2);
    $display("test queue done");
    ques_cond_pin = 16'h0001;
    wr_data = 16'h0020;
    go(14'h1 << ESE);
    go(14'h1 << SRE);
    wr_data = 16'h0002;
    go(14'h1 << QEN);
    wr_data = 16'hFFFF;
    go(14'h1 << OEN);
    idle(2);
    chk("ese", 16'h0020, ese_m);
    chk("sre", 16'h0020, sre_m);
    chk("qen", 16'h0002, qm);
    chk("oen", 16'hFFFF, om);
    err_code = codes[0];
    go(14'h1 << PUSH);
    idle(8);
    chk("sbyte", 16'h0064, sb);
    chk("srqline", 16'h0000, srq_line);
    poll = 1'b1;
    go(14'h0000);
    poll = 1'b0;
    chk("poll", 16'h0064, poll_byte);
    ques_cond_pin = 16'h0003;
    wt(3);
    chk("quesrd", 16'h0003, qrd);
    go(14'h1 << QRD);
    idle(2);
    chk("quesclr", 16'h0000, qrd);
    chk("ques", 16'h0000, sb[3]);
    local_btn_pin = 1'b1;
    wt(14);
    go(14'h1 << CLS);
    idle(2);
    chk("cls", 16'h0000, sel);
    chk("sbyte", 16'h0000, sb);
    chk("srqline", 16'h0001, srq_line);
    $display("test masks done");
    oq_wdata = 8'hA5;
    go(14'h1 << OQW);
    oq_wdata = 8'h3C;
    go(14'h1 << OQW);
    idle(2);
    chk("mav", 16'h0001, sb[4]);
    go(14'h1 << OQR);
    chk("oqdata", 16'h01A5, {7'h00, oq_rvalid, oq_rdata});
    go(14'h0000);
    chk("rvalid", 16'h0000, oq_rvalid);
    go(14'h1 << MSG);
    idle(2);
    chk("mav", 16'h0000, sb[4]);
    $display("test output queue done");
    go(14'h1 << OPC);
    go(14'h1 << DONE);
    idle(2);
    chk("opc", 16'h0001, sel & 8'h03);
    $display("test opc done");
    final_report;
  end
endmodule // test_instrument_status_reporting
